// ### logic/pcr_power_ctrl.sv
/*
 * Power control register with Avalon-MM slave: regulator mode, battery
 * charging, low-power regulator drive, backup write gate, voltage
 * detector setup, flag-clear strobes and low-power mode select.
 * Assumes a single 200 MHz clock; PLL, deep-sleep and wakeup inputs come
 * from other domains and are synchronised here.
 */
// Local design decisions: the register addresses and the Avalon-MM slave port.
// Contract
// - Voltage field applies only with PLL on; low mode otherwise, field kept.
// - Voltage code 10 adaptive, 11 high, upper bit 0 reserved.
// - Bit 12 enables charging; bit 13 picks 5k (0) or 1.5k (1) resistor.
// - Bit 11 sets low-drive of low-power regulator in Run and Sleep.
// - Bit 10 sets low-drive of low-power regulator in Deep-sleep.
// - Backup writes blocked after reset until the write-enable bit is set.
// - Threshold codes 000..110 pick 2.1..3.0 V; 111 compares external pin.
// - Detector runs only while bit 4 is set.
// - Writing 1 to bit 3 clears standby flag; reads zero.
// - Writing 1 to bit 2 clears wakeup flag; reads zero.
// - On processor deep sleep enter the mode in the two-bit field.
// - Register resets to 0x0000C000 at power-on and on standby wakeup.
// - Standby and wakeup flags clear only on power reset or strobes.
module pcr_power_ctrl (
  // Clock and reset
  input  wire logic                            i_sys_clk,
  input  wire logic                            i_reset,
  // Avalon-MM slave
  input  wire logic [pcr_pkg::PCR_ADDR_W-1:0]  i_avs_address,
  input  wire logic                            i_avs_read,
  input  wire logic                            i_avs_write,
  input  wire logic [31:0]                     i_avs_writedata,
  input  wire logic [3:0]                      i_avs_byteenable,
  output logic      [31:0]                     o_avs_readdata,
  output logic                                 o_avs_waitrequest,
  // Power sequencing inputs
  input  wire logic                            i_pll_enabled,
  input  wire logic                            i_cpu_deep_sleep_request,
  input  wire logic                            i_standby_wakeup_reset,
  input  wire logic                            i_standby_entered,
  input  wire logic                            i_wakeup_event,
  // Backup domain write request
  input  wire logic                            i_backup_write_req,
  // Control outputs
  output pcr_pkg::pcr_ctrl_s                   o_ctrl,
  output pcr_pkg::pcr_lp_req_s                 o_lp_req,
  output logic                                 o_backup_write_strobe,
  output logic                                 o_standby_flag,
  output logic                                 o_wakeup_flag
);
  import pcr_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The decode below assumes these field widths; a package edit that
  // moves a field must stop here rather than silently misdecode.
  if (PCR_VS_HI != PCR_VS_LO + 1) begin : g_bad_vs
    $error("voltage field must be two bits wide");
  end
  if (PCR_TH_HI != PCR_TH_LO + 2) begin : g_bad_th
    $error("threshold field must be three bits wide");
  end
  if (PCR_LPM_HI != PCR_LPM_LO + 1) begin : g_bad_lpm
    $error("low-power mode field must be two bits wide");
  end
  if (PCR_VS_HI > 31) begin : g_bad_top
    $error("control fields must fit in 32 bits");
  end
  // Strobes must never be stored, or they would read back as one
  if (PCR_CTL0_WMASK[PCR_STBCLR] || PCR_CTL0_WMASK[PCR_WUCLR]) begin : g_bad_strobe
    $error("flag-clear strobes must stay out of the storage mask");
  end
  if ((PCR_CTL0_RESET & ~PCR_CTL0_WMASK) != 32'h0000_0000) begin : g_bad_reset
    $error("reset value sets bits that are not stored");
  end
  if (PCR_ADDR_W < 3) begin : g_bad_addr
    $error("address too narrow to reach the status register");
  end
  if (PCR_OFF_CTL0 == PCR_OFF_STATUS) begin : g_bad_map
    $error("control and status offsets must differ");
  end
  if (PCR_ST_WU == PCR_ST_STB) begin : g_bad_status
    $error("status flag bits must differ");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned N_SYNC = 5;
  logic [N_SYNC-1:0] async_in;
  logic [N_SYNC-1:0] sync_in;
  assign async_in = {i_pll_enabled, i_cpu_deep_sleep_request, i_standby_wakeup_reset,
                     i_standby_entered, i_wakeup_event};

  // One chain per level; nothing reads a level before its second flop
  genvar gi;
  generate
    for (gi = 0; gi < N_SYNC; gi++) begin : g_sync
      pcr_sync2 u_sync (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_async   (async_in[gi]),
        .o_sync    (sync_in[gi])
      );
    end
  endgenerate

  logic pll_on;
  logic deep_sleep;
  logic stby_wake;
  logic stby_evt;
  logic wake_evt;
  assign {pll_on, deep_sleep, stby_wake, stby_evt, wake_evt} = sync_in;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0]  ctl_q, ctl_d;
  logic         stb_q, stb_d;
  logic         wu_q, wu_d;
  logic         stby_evt_q, stby_evt_d;
  logic         wake_evt_q, wake_evt_d;
  logic         ack_q, ack_d;
  logic [31:0]  rdata_q, rdata_d;
  pcr_ctrl_s    ctrl_q, ctrl_d;
  pcr_lp_req_s  lp_q, lp_d;
  logic         bkw_q, bkw_d;

  logic         req;
  logic         wr_ctl;
  logic [31:0]  be_mask;

  // The ack flop blocks a request still held in the answer cycle, so it is taken once
  assign req     = (i_avs_read | i_avs_write) & ~ack_q;
  assign wr_ctl  = i_avs_write & ~ack_q & (i_avs_address == PCR_OFF_CTL0);
  assign be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                    {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  // ----------------------------------------------------------------
  // Register and flag next state
  // ----------------------------------------------------------------
  always_comb begin
    ctl_d      = ctl_q;
    stb_d      = stb_q;
    wu_d       = wu_q;
    stby_evt_d = stby_evt;
    wake_evt_d = wake_evt;
    // Wakeup from standby reloads the word but keeps the flags, which only
    // a power reset or a strobe may clear
    if (stby_wake) begin
      ctl_d = PCR_CTL0_RESET;
    end else if (wr_ctl) begin
      // Reserved bits and strobes are masked out of storage
      ctl_d = (ctl_q & ~(be_mask & PCR_CTL0_WMASK))
            | (i_avs_writedata & be_mask & PCR_CTL0_WMASK);
    end
    // Strobe clears first; a fresh event in the same cycle wins
    if (wr_ctl && be_mask[PCR_STBCLR] && i_avs_writedata[PCR_STBCLR]) begin
      stb_d = 1'b0;
    end
    if (wr_ctl && be_mask[PCR_WUCLR] && i_avs_writedata[PCR_WUCLR]) begin
      wu_d = 1'b0;
    end
    if (stby_evt && !stby_evt_q) begin
      stb_d = 1'b1;
    end
    if (wake_evt && !wake_evt_q) begin
      wu_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer: one wait cycle, then ack
  // ----------------------------------------------------------------
  always_comb begin
    // Read data is latched in the take cycle and holds until the next read
    ack_d   = req;
    rdata_d = rdata_q;
    if (req && i_avs_read) begin
      case (i_avs_address)
        PCR_OFF_CTL0: begin
          rdata_d = ctl_q & PCR_CTL0_WMASK;
        end
        PCR_OFF_STATUS: begin
          rdata_d = PCR_UNMAPPED_DATA;
          rdata_d[PCR_ST_WU]  = wu_q;
          rdata_d[PCR_ST_STB] = stb_q;
          rdata_d[PCR_ST_PLL] = pll_on;
        end
        default: begin
          rdata_d = PCR_UNMAPPED_DATA;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  always_comb begin
    // Every output leaves a flop, one clock behind the stored word. The backup
    // gate reads the stored bit itself, so it closes on the write that clears it.
    ctrl_d = '0;
    if (!pll_on || !ctl_q[PCR_VS_HI]) begin
      ctrl_d.reg_mode = PCR_REG_LOW;
    end else if (ctl_q[PCR_VS_HI:PCR_VS_LO] == PCR_VS_HIGH) begin
      ctrl_d.reg_mode = PCR_REG_HIGH;
    end else begin
      ctrl_d.reg_mode = PCR_REG_ADAPTIVE;
    end
    ctrl_d.charge_en      = ctl_q[PCR_CHGEN];
    ctrl_d.charge_res_low = ctl_q[PCR_CRSEL];
    // Drive bit follows the current state: deep sleep uses its own bit
    ctrl_d.lp_low_drive   = deep_sleep ? ctl_q[PCR_LDDSP]
                                       : ctl_q[PCR_LDRUN];
    ctrl_d.backup_write_en    = ctl_q[PCR_BKWEN];
    ctrl_d.detector_en        = ctl_q[PCR_DETEN];
    ctrl_d.detector_threshold = ctl_q[PCR_TH_HI:PCR_TH_LO];
    ctrl_d.detector_ext_pin   = ctl_q[PCR_DETEN] &
                                (ctl_q[PCR_TH_HI:PCR_TH_LO] == PCR_TH_EXT_PIN);
    lp_d.enter = deep_sleep;
    case (ctl_q[PCR_LPM_HI:PCR_LPM_LO])
      2'h0:    lp_d.mode = PCR_LP_DEEP;
      2'h1:    lp_d.mode = PCR_LP_DEEP1;
      2'h2:    lp_d.mode = PCR_LP_DEEP2;
      default: lp_d.mode = PCR_LP_STANDBY;
    endcase
    bkw_d = i_backup_write_req & ctl_q[PCR_BKWEN];
  end

  // ----------------------------------------------------------------
  // Registers, one process per group of state
  // ----------------------------------------------------------------
  // Control word and flags
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ctl_q      <= PCR_CTL0_RESET;
      stb_q      <= 1'b0;
      wu_q       <= 1'b0;
      stby_evt_q <= 1'b0;
      wake_evt_q <= 1'b0;
    end else begin
      ctl_q      <= ctl_d;
      stb_q      <= stb_d;
      wu_q       <= wu_d;
      stby_evt_q <= stby_evt_d;
      wake_evt_q <= wake_evt_d;
    end
  end

  // Bus answer
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ack_q   <= 1'b0;
      rdata_q <= PCR_UNMAPPED_DATA;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // Decoded outputs
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_q <= '0;
      lp_q   <= '0;
      bkw_q  <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      lp_q   <= lp_d;
      bkw_q  <= bkw_d;
    end
  end

  // ----------------------------------------------------------------
  // Waitrequest
  // ----------------------------------------------------------------
  // High while idle so a new request first waits; it mirrors the ack flop,
  // but a flop of its own keeps the output free of logic after the flop
  logic wait_q, wait_d;
  always_comb begin
    wait_d = ~req;
  end
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= wait_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_avs_readdata        = rdata_q;
  assign o_avs_waitrequest     = wait_q;
  assign o_ctrl                = ctrl_q;
  assign o_lp_req              = lp_q;
  assign o_backup_write_strobe = bkw_q;
  assign o_standby_flag        = stb_q;
  assign o_wakeup_flag         = wu_q;

endmodule : pcr_power_ctrl

// ### logic/pcr_pkg.sv
/*
 * Package for the power control register block: register map, field
 * positions, reset value, decoded mode enumerations and carrier structs.
 * Assumes a 32-bit Avalon-MM slave with word addressing in bytes.
 */
package pcr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned       PCR_ADDR_W         = 4;
  localparam logic [3:0]        PCR_OFF_CTL0       = 4'h0;
  localparam logic [3:0]        PCR_OFF_STATUS     = 4'h4;
  localparam logic [31:0]       PCR_CTL0_RESET     = 32'h0000_C000;
  localparam logic [31:0]       PCR_CTL0_WMASK     = 32'h0000_FDF3;
  localparam logic [31:0]       PCR_UNMAPPED_DATA  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned PCR_VS_HI   = 15;
  localparam int unsigned PCR_VS_LO   = 14;
  localparam int unsigned PCR_CRSEL   = 13;
  localparam int unsigned PCR_CHGEN   = 12;
  localparam int unsigned PCR_LDRUN   = 11;
  localparam int unsigned PCR_LDDSP   = 10;
  localparam int unsigned PCR_BKWEN   = 8;
  localparam int unsigned PCR_TH_HI   = 7;
  localparam int unsigned PCR_TH_LO   = 5;
  localparam int unsigned PCR_DETEN   = 4;
  localparam int unsigned PCR_STBCLR  = 3;
  localparam int unsigned PCR_WUCLR   = 2;
  localparam int unsigned PCR_LPM_HI  = 1;
  localparam int unsigned PCR_LPM_LO  = 0;
  // Status register (own layout)
  localparam int unsigned PCR_ST_WU   = 0;
  localparam int unsigned PCR_ST_STB  = 1;
  localparam int unsigned PCR_ST_PLL  = 2;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] PCR_VS_ADAPTIVE = 2'h2;
  localparam logic [1:0] PCR_VS_HIGH     = 2'h3;
  localparam logic [2:0] PCR_TH_EXT_PIN  = 3'h7;

  typedef enum logic [1:0] {
    PCR_REG_LOW,
    PCR_REG_ADAPTIVE,
    PCR_REG_HIGH
  } pcr_reg_mode_e;

  typedef enum logic [1:0] {
    PCR_LP_DEEP,
    PCR_LP_DEEP1,
    PCR_LP_DEEP2,
    PCR_LP_STANDBY
  } pcr_lp_mode_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    pcr_reg_mode_e reg_mode;
    logic          charge_en;
    logic          charge_res_low;
    logic          lp_low_drive;
    logic          backup_write_en;
    logic          detector_en;
    logic [2:0]    detector_threshold;
    logic          detector_ext_pin;
  } pcr_ctrl_s;

  typedef struct packed {
    logic         enter;
    pcr_lp_mode_e mode;
  } pcr_lp_req_s;

endpackage : pcr_pkg

// ### logic/pcr_sync2.sv
/*
 * Two-flop synchroniser for one level from outside the clock domain.
 * Assumes the input is a level that stays stable for several clocks.
 */
module pcr_sync2 (
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  input  wire logic i_async,
  output logic      o_sync
);

  logic meta_q;
  logic meta_d;
  logic sync_d;

  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  // First flop feeds only the second
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_q <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_q <= meta_d;
      o_sync <= sync_d;
    end
  end

endmodule : pcr_sync2

// ### verification/pcr_seq_model.sv
/* Power sequencing partner: turns bench commands into PLL, deep sleep,
   standby, wakeup and standby-wakeup-reset levels, promptly or late.
   Assumes commands change only while the block is idle. */
module pcr_seq_model (
  // Clock and commands
  input  wire logic       i_sys_clk,
  input  wire logic       i_slow,
  input  wire logic [4:0] i_cmd,
  // Levels to the block
  output logic      [4:0] o_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] pipe [3];
  // Late answers lag three cycles, like slow analog settling
  always @(posedge i_sys_clk) begin
    pipe[0] <= i_cmd;
    pipe[1] <= pipe[0];
    pipe[2] <= pipe[1];
  end
  // Slow mode answers from the end of the pipe; otherwise commands pass straight through
  assign o_lvl = i_slow ? pipe[2] : i_cmd;
endmodule : pcr_seq_model

// ### verification/pcr_power_ctrl_sva.sv
/* Port checker for pcr_power_ctrl, bound below the module.
   Assumes one clock and the async active-high reset. */
module pcr_power_ctrl_sva (
  input wire logic                  i_sys_clk,
  input wire logic                  i_reset,
  input wire logic [3:0]            i_avs_address,
  input wire logic                  i_avs_read,
  input wire logic                  i_avs_write,
  input wire logic                  i_pll_enabled,
  input wire logic                  i_cpu_deep_sleep_request,
  input wire logic                  i_backup_write_req,
  input wire logic [31:0]           o_avs_readdata,
  input wire logic                  o_avs_waitrequest,
  input wire pcr_pkg::pcr_ctrl_s    o_ctrl,
  input wire pcr_pkg::pcr_lp_req_s  o_lp_req,
  input wire logic                  o_backup_write_strobe,
  input wire logic                  o_standby_flag,
  input wire logic                  o_wakeup_flag
);
  import pcr_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  logic rd_ctl;
  assign rd_ctl = i_avs_read && !o_avs_waitrequest && i_avs_address == PCR_OFF_CTL0;

  AST_ACK_ONE: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=>
    !o_avs_waitrequest ##1 o_avs_waitrequest) else $error("ack not one cycle");
  AST_IDLE_WAIT: assert property (!(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
    else $error("ack without request");
  AST_STROBE_RD0: assert property (rd_ctl |-> o_avs_readdata[3:2] == 2'h0)
    else $error("strobe bits read nonzero");
  AST_RSVD_RD0: assert property (rd_ctl |-> o_avs_readdata[31:16] == 16'h0000 && !o_avs_readdata[9])
    else $error("reserved bits read nonzero");
  AST_UNMAPPED: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address != PCR_OFF_CTL0
    && i_avs_address != PCR_OFF_STATUS |-> o_avs_readdata == PCR_UNMAPPED_DATA) else $error("unmapped read");
  AST_PLL_OFF_LOW: assert property (!i_pll_enabled [*4] |-> o_ctrl.reg_mode == PCR_REG_LOW)
    else $error("regulator not low with pll off");
  AST_DEEP_ENTER: assert property ($stable(i_cpu_deep_sleep_request) [*4] |->
    o_lp_req.enter == i_cpu_deep_sleep_request) else $error("enter does not follow deep sleep");
  AST_BACKUP_GATE: assert property (o_backup_write_strobe |-> $past(i_backup_write_req)
    && (o_ctrl.backup_write_en || $past(o_ctrl.backup_write_en))) else $error("backup write not gated");
  AST_FLAG_CLR: assert property ($fell(o_wakeup_flag) || $fell(o_standby_flag) |->
    $past(i_avs_write) && $past(i_avs_address) == PCR_OFF_CTL0) else $error("flag cleared without write");
  AST_EXT_PIN: assert property (o_ctrl.detector_ext_pin |-> o_ctrl.detector_threshold == PCR_TH_EXT_PIN)
    else $error("external pin with wrong code");
endmodule : pcr_power_ctrl_sva

bind pcr_power_ctrl pcr_power_ctrl_sva u_sva (.i_sys_clk, .i_reset, .i_avs_address, .i_avs_read,
  .i_avs_write, .i_pll_enabled, .i_cpu_deep_sleep_request, .i_backup_write_req, .o_avs_readdata,
  .o_avs_waitrequest, .o_ctrl, .o_lp_req, .o_backup_write_strobe, .o_standby_flag, .o_wakeup_flag);

// ### verification/pcr_power_ctrl_tb_top.sv
/* Self-checking bench: Avalon master, shadow model of the control word
   and flags, partner sequencer. Assumes the checker binds itself. */
module pcr_power_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pcr_pkg::*;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
  logic        clk = 0, rst = 1, rd = 0, wr = 0, slow = 0, bkreq = 0;
  logic [3:0]  adr = 0, be = 0, b;
  logic [31:0] wd = 0, rdata, d;
  logic [4:0]  cmd = 0, lvl;
  logic        waitreq, bkstb, sflag, wflag;
  pcr_ctrl_s   ctrl;
  pcr_lp_req_s lp;
  int          err_total = 0, n_checks = 0, seed = 29191, sh, exs, exw;
  always #2.5 clk = ~clk;
  pcr_seq_model u_seq (.i_sys_clk(clk), .i_slow(slow), .i_cmd(cmd), .o_lvl(lvl));
  pcr_power_ctrl u_dut (.i_sys_clk(clk), .i_reset(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_pll_enabled(lvl[0]), .i_cpu_deep_sleep_request(lvl[1]),
    .i_standby_entered(lvl[2]), .i_wakeup_event(lvl[3]), .i_standby_wakeup_reset(lvl[4]),
    .i_backup_write_req(bkreq), .o_ctrl(ctrl), .o_lp_req(lp), .o_backup_write_strobe(bkstb),
    .o_standby_flag(sflag), .o_wakeup_flag(wflag));
  // ----------------------------------------------------------------
  // Model and tasks
  // ----------------------------------------------------------------
  function automatic pcr_ctrl_s exp_ctrl(logic [4:0] c);
    pcr_ctrl_s e;
    e.reg_mode = !(c[0] && sh[15]) ? PCR_REG_LOW : sh[14] ? PCR_REG_HIGH : PCR_REG_ADAPTIVE;
    e.charge_en = sh[12];
    e.charge_res_low = sh[13];
    e.lp_low_drive = c[1] ? sh[10] : sh[11];
    e.backup_write_en = sh[8];
    e.detector_en = sh[4];
    e.detector_threshold = sh[7:5];
    e.detector_ext_pin = sh[4] && sh[7:5] == 3'h7;
    return e;
  endfunction : exp_ctrl
  task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] dd, input logic [3:0] bb);
    @(posedge clk);
    adr <= a;
    wd <= dd;
    be <= bb;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (waitreq !== 1'b0);
    if (w && a == PCR_OFF_CTL0) begin
      for (int i = 0; i < 4; i++) if (bb[i]) sh[8*i +: 8] = dd[8*i +: 8] & PCR_CTL0_WMASK[8*i +: 8];
      if (bb[0] && dd[3]) exs = 0;
      if (bb[0] && dd[2]) exw = 0;
    end
    if (!w && a == PCR_OFF_STATUS) `CHK(rdata, {29'h0, lvl[0], exs[0], exw[0]})
    else if (!w) `CHK(rdata, (a == PCR_OFF_CTL0) ? 32'(sh) : PCR_UNMAPPED_DATA)
    wr <= 0;
    rd <= 0;
  endtask : bus
  task automatic drive(logic [4:0] c);
    if (c[2] && !cmd[2]) exs = 1;
    if (c[3] && !cmd[3]) exw = 1;
    @(posedge clk);
    cmd <= c;
    repeat (8) @(posedge clk);
    `CHK(ctrl, exp_ctrl(c))
    `CHK(lp, {c[1], sh[1:0]})
    `CHK(sflag, exs[0])
    `CHK(wflag, exw[0])
  endtask : drive
  task automatic complete_run();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    complete_run();
  end
  initial begin
    sh = PCR_CTL0_RESET;
    exs = 0;
    exw = 0;
    repeat (8) @(posedge clk);
    rst <= 0;
    bus(0, PCR_OFF_CTL0, 0, 0);
    for (int k = 0; k < 48; k++) begin
      slow <= k[1];
      drive({1'b0, 3'($random(seed)), 1'b0});
      d = $random(seed);
      if (k > 0) d = d & 32'h0000_FDFF;
      b = k[0] ? 4'hF : (k[2] ? 4'h3 : 4'hC);
      bus(1, (k % 5 == 4) ? 4'(8 + k % 8) : PCR_OFF_CTL0, d, b);
      bus(0, (k % 5 == 4) ? 4'(8 + k % 8) : PCR_OFF_CTL0, 0, 0);
      drive(5'($random(seed)) & 5'h0F);
      bus(0, PCR_OFF_STATUS, 0, 0);
      @(posedge clk);
      bkreq <= 1;
      @(posedge clk);
      bkreq <= 0;
      @(posedge clk);
      `CHK(bkstb, sh[8])
    end
    sh = PCR_CTL0_RESET;
    drive(cmd | 5'h10);
    drive(cmd & 5'h0F);
    bus(0, PCR_OFF_CTL0, 0, 0);
    bus(0, PCR_OFF_STATUS, 0, 0);
    // Power reset mid-run with quiet levels: word and both flags return to reset
    drive(5'h00);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    sh = PCR_CTL0_RESET;
    exs = 0;
    exw = 0;
    bus(0, PCR_OFF_CTL0, 0, 0);
    bus(0, PCR_OFF_STATUS, 0, 0);
    `CHK(sflag, 1'b0)
    `CHK(wflag, 1'b0)
    complete_run();
  end
endmodule : pcr_power_ctrl_tb_top
